// ===== hdl/pcs_map.vh
// register map, field positions, reset values and timing counts of the clock synthesis control
`ifndef PCS_MAP_VH
`define PCS_MAP_VH

// loop count and address layout: paddr[6:4] picks the loop, paddr[3:0] the word
`define PCS_NUM_LOOPS 5
`define PCS_REFS_PER_LOOP 4

// word offsets inside one loop window
`define PCS_OFS_CTRL 4'h0
`define PCS_OFS_MN 4'h4
`define PCS_OFS_CDIV 4'h8
`define PCS_OFS_STAT 4'hc

// control word fields
`define PCS_CTRL_RUN 0
`define PCS_CTRL_SEL_LSB 1
`define PCS_CTRL_SRC_LSB 3
`define PCS_CTRL_FB_LSB 5
`define PCS_CTRL_O_LSB 8
`define PCS_CTRL_OE_LSB 10

// multiplier / pre-divider word fields
`define PCS_MN_M_LSB 0
`define PCS_MN_N_LSB 8

// reference source modes
`define PCS_SRC_EXT 2'h0
`define PCS_SRC_CORE 2'h1
`define PCS_SRC_DYN 2'h2
`define PCS_SRC_LVDS 2'h3

// feedback modes
`define PCS_FB_INT 2'h0
`define PCS_FB_LOCAL 2'h1
`define PCS_FB_CORE 2'h2

// reset values
`define PCS_CTRL_RST 32'h00001d00
`define PCS_MN_RST 32'h00000101
`define PCS_CDIV_RST 32'h00000000

// timing: clock period and least loop reset pulse, in ns, and derived cycles
`define PCS_CLK_PERIOD_NS 100
`define PCS_RST_MIN_NS 10
`define PCS_RST_MIN_CYC ((`PCS_RST_MIN_NS + `PCS_CLK_PERIOD_NS - 1) / `PCS_CLK_PERIOD_NS)
`define PCS_LOCK_PERIODS 4

`endif

// ===== hdl/pcs_out_div.v
// output clock divider of one synthesis loop
`timescale 1ns/1ps
module pcs_out_div (
    input wire clk,
    input wire ce,
    input wire srst_n,
    input wire en,
    input wire tick,
    input wire [7:0] div_m1,
    output reg clk_out_ff
);
    reg [7:0] cnt_ff;
    wire [8:0] half = ({1'b0, div_m1} + 9'h001) >> 1;
    wire [7:0] nxt_cnt = (cnt_ff == div_m1) ? 8'h00 : cnt_ff + 8'h01;

    // divide post-divider ticks by div_m1+1; c of one passes each tick through
    always @(posedge clk) begin
        if (!srst_n || !en) begin
            cnt_ff <= 8'h00;
            clk_out_ff <= 1'b0;
        end else if (ce) begin
            if (div_m1 == 8'h00) begin
                clk_out_ff <= tick;
            end else if (tick) begin
                cnt_ff <= nxt_cnt;
                clk_out_ff <= ({1'b0, nxt_cnt} < half);
            end
        end
    end
endmodule // pcs_out_div

// ===== hdl/pcs_lock_det.v
// lock detector: counts stable detector periods, holds when reference stops
`timescale 1ns/1ps
`include "pcs_map.vh"
module pcs_lock_det (
    input wire clk,
    input wire ce,
    input wire srst_n,
    input wire tick,
    input wire [15:0] new_period,
    input wire [15:0] old_period,
    input wire fb_ok,
    output reg locked_ff
);
    reg [2:0] good_ff;
    wire [15:0] diff = (new_period > old_period) ? new_period - old_period :
                       old_period - new_period;
    wire good = (diff <= 16'h0001) && fb_ok;

    // state only moves on a detector tick, so a stalled reference freezes it
    always @(posedge clk) begin
        if (!srst_n) begin
            good_ff <= 3'h0;
            locked_ff <= 1'b0;
        end else if (ce && tick) begin
            if (!good) begin
                good_ff <= 3'h0;
                locked_ff <= 1'b0;
            end else if (good_ff == `PCS_LOCK_PERIODS - 1) begin
                locked_ff <= 1'b1;
            end else begin
                good_ff <= good_ff + 3'h1;
            end
        end
    end
endmodule // pcs_lock_det

// ===== hdl/pcs_top.v
// clock synthesis control: apb registers and five digital synthesis loops
//
// Local design decisions: the APB slave port and the placing of the registers.
`timescale 1ns/1ps
`include "pcs_map.vh"
module pcs_top (
    input wire clk,
    input wire rst_n,
    input wire ce,
    input wire psel,
    input wire penable,
    input wire pwrite,
    input wire [7:0] paddr,
    input wire [31:0] pwdata,
    output reg [31:0] prdata,
    output reg pready,
    output reg pslverr,
    input wire [19:0] ref_clock_inputs,
    input wire lvds_rx_ref_clock,
    input wire [4:0] fabric_feedback_clock,
    output wire [4:0] synth_out_zero,
    output wire [4:0] synth_out_one,
    output wire [4:0] synth_out_two,
    output wire [4:0] locked
);
    // post-divider code to value, shared by vco scaling and post divider
    function [3:0] o_val;
        input [1:0] code;
        begin
            o_val = 4'h1 << code;
        end
    endfunction

    // zero in a divider field is taken as one so the loop never stalls
    function [7:0] nz8;
        input [7:0] v;
        begin
            nz8 = (v == 8'h00) ? 8'h01 : v;
        end
    endfunction

    // per-loop register storage
    reg [31:0] ctrl_ff [0:4];
    reg [31:0] mn_ff [0:4];
    reg [31:0] cdiv_ff [0:4];

    // status collected from the loops
    wire [4:0] stall_w;
    wire [79:0] period_w;
    wire [4:0] out0_w;
    // least loop reset stretch in cycles, cut to the counter width on purpose
    wire [31:0] rst_min_w = `PCS_RST_MIN_CYC;

    // apb decode
    wire setup = psel & ~penable;
    wire access = psel & penable & pready;
    wire [2:0] lidx = paddr[6:4];
    wire hit = (paddr[7] == 1'b0) && (lidx < 3'h5) && (paddr[1:0] == 2'h0);
    reg [31:0] rd_word;

    // read mux over the addressed loop window
    always @* begin
        rd_word = 32'h00000000;
        if (hit) begin
            case (paddr[3:0])
                `PCS_OFS_CTRL: rd_word = ctrl_ff[lidx];
                `PCS_OFS_MN: rd_word = mn_ff[lidx];
                `PCS_OFS_CDIV: rd_word = cdiv_ff[lidx];
                `PCS_OFS_STAT: rd_word = {period_w[lidx*16 +: 16], 14'h0000,
                                          stall_w[lidx], locked[lidx]};
                default: rd_word = 32'h00000000;
            endcase
        end
    end

    // apb handshake: one wait-free access cycle after each setup
    always @(posedge clk) begin
        if (!rst_n) begin
            pready <= 1'b0;
            pslverr <= 1'b0;
            prdata <= 32'h00000000;
        end else if (ce) begin
            pready <= setup;
            if (setup) begin
                pslverr <= ~hit;
                prdata <= pwrite ? 32'h00000000 : rd_word;
            end
        end
    end

    // register writes; status word is read only and ignores writes
    integer i;
    always @(posedge clk) begin
        if (!rst_n) begin
            for (i = 0; i < `PCS_NUM_LOOPS; i = i + 1) begin
                ctrl_ff[i] <= `PCS_CTRL_RST;
                mn_ff[i] <= `PCS_MN_RST;
                cdiv_ff[i] <= `PCS_CDIV_RST;
            end
        end else if (ce && access && pwrite && hit) begin
            case (paddr[3:0])
                `PCS_OFS_CTRL: ctrl_ff[lidx] <= {19'h00000, pwdata[12:0]};
                `PCS_OFS_MN: mn_ff[lidx] <= {20'h00000, pwdata[11:0]};
                `PCS_OFS_CDIV: cdiv_ff[lidx] <= {8'h00, pwdata[23:0]};
                default: ;
            endcase
        end
    end

    genvar g;
    generate
        for (g = 0; g < `PCS_NUM_LOOPS; g = g + 1) begin : loop
            wire [31:0] ctl = ctrl_ff[g];
            wire [31:0] mn = mn_ff[g];
            wire [31:0] cd = cdiv_ff[g];
            wire [1:0] fb = ctl[`PCS_CTRL_FB_LSB +: 2];
            wire [3:0] ov = o_val(ctl[`PCS_CTRL_O_LSB +: 2]);
            wire [7:0] mv = nz8(mn[`PCS_MN_M_LSB +: 8]);
            wire [3:0] nv = (mn[`PCS_MN_N_LSB +: 4] == 4'h0) ? 4'h1 :
                            mn[`PCS_MN_N_LSB +: 4];
            wire [8:0] c0v = {1'b0, cd[7:0]} + 9'h001;

            reg [3:0] rcnt_ff;
            reg [1:0] sel_ff;
            reg [1:0] src_ff;
            reg ref_q_ff;
            reg fb_q_ff;
            reg [3:0] ncnt_ff;
            reg [15:0] pcnt_ff;
            reg [15:0] period_ff;
            reg [15:0] prev_ff;
            reg seen_ff;
            reg pvalid_ff;
            reg [23:0] acc_ff;
            reg vt_ff;
            reg [2:0] ocnt_ff;
            reg pll_ff;
            reg [7:0] fbcnt_ff;
            reg ref_pick;

            // software run bit is the loop enable; stretched low for a least pulse
            wire lr_n = ctl[`PCS_CTRL_RUN] && (rcnt_ff == 4'h0);
            wire srst_n = rst_n & lr_n;

            always @(posedge clk) begin
                if (!rst_n) begin
                    rcnt_ff <= 4'h0;
                end else if (ce) begin
                    if (!ctl[`PCS_CTRL_RUN]) begin
                        rcnt_ff <= rst_min_w[3:0];
                    end else if (rcnt_ff != 4'h0) begin
                        rcnt_ff <= rcnt_ff - 4'h1;
                    end
                end
            end

            // select and source are only taken while the loop is in reset,
            // so a change made while running cannot glitch the reference
            always @(posedge clk) begin
                if (!rst_n) begin
                    sel_ff <= 2'h0;
                    src_ff <= `PCS_SRC_EXT;
                end else if (ce && !lr_n) begin
                    sel_ff <= ctl[`PCS_CTRL_SEL_LSB +: 2];
                    src_ff <= ctl[`PCS_CTRL_SRC_LSB +: 2];
                end
            end

            // reference routing: fixed pad, fixed core, dynamic, or lvds on loop 0 only (other loops get a constant low)
            always @* begin
                case (src_ff)
                    `PCS_SRC_EXT: ref_pick = ref_clock_inputs[g*4];
                    `PCS_SRC_CORE: ref_pick = ref_clock_inputs[g*4+1];
                    `PCS_SRC_DYN: ref_pick = ref_clock_inputs[g*4+sel_ff];
                    `PCS_SRC_LVDS: ref_pick = (g == 0) ? lvds_rx_ref_clock : 1'b0;
                    default: ref_pick = 1'b0;
                endcase
            end

            wire ref_rise = ref_pick & ~ref_q_ff;
            wire pfd = ref_rise && (ncnt_ff == nv - 4'h1);

            // pre-divider and detector period measurement
            always @(posedge clk) begin
                if (!srst_n) begin
                    ref_q_ff <= 1'b0;
                    ncnt_ff <= 4'h0;
                    pcnt_ff <= 16'h0000;
                    period_ff <= 16'h0000;
                    prev_ff <= 16'h0000;
                    seen_ff <= 1'b0;
                    pvalid_ff <= 1'b0;
                end else if (ce) begin
                    ref_q_ff <= ref_pick;
                    if (ref_rise) begin
                        ncnt_ff <= pfd ? 4'h0 : ncnt_ff + 4'h1;
                    end
                    if (pfd) begin
                        pcnt_ff <= 16'h0000;
                        seen_ff <= 1'b1;
                        pvalid_ff <= seen_ff;
                        if (seen_ff) begin
                            period_ff <= pcnt_ff + 16'h0001;
                            prev_ff <= period_ff;
                        end
                    end else if (pcnt_ff != 16'hffff) begin
                        pcnt_ff <= pcnt_ff + 16'h0001;
                    end
                end
            end

            // vco multiplier: m alone, or m*o*c0 when the output closes the loop
            wire [20:0] fb_mult = mv * ov * c0v;
            wire [20:0] mult = (fb == `PCS_FB_INT) ? {13'h0000, mv} : fb_mult;
            wire [23:0] sum = acc_ff + {3'h0, mult};
            wire [23:0] per24 = {8'h00, period_ff};
            wire [23:0] rem = sum - per24;

            // rate accumulator emits mult vco ticks per detector period;
            // limitation: at most one tick per clock, faster rates saturate
            always @(posedge clk) begin
                if (!srst_n) begin
                    acc_ff <= 24'h000000;
                    vt_ff <= 1'b0;
                end else if (ce) begin
                    vt_ff <= 1'b0;
                    if (pvalid_ff) begin
                        if (fb != `PCS_FB_INT && pfd) begin
                            // last tick of a period lands on the detector edge; keep it
                            acc_ff <= 24'h000000;
                            vt_ff <= (sum >= per24);
                        end else if (sum >= per24) begin
                            acc_ff <= (rem > per24) ? per24 : rem;
                            vt_ff <= 1'b1;
                        end else begin
                            acc_ff <= sum;
                        end
                    end
                end
            end

            // post divider o
            always @(posedge clk) begin
                if (!srst_n) begin
                    ocnt_ff <= 3'h0;
                    pll_ff <= 1'b0;
                end else if (ce) begin
                    pll_ff <= 1'b0;
                    if (vt_ff) begin
                        if ({1'b0, ocnt_ff} == ov - 4'h1) begin
                            ocnt_ff <= 3'h0;
                            pll_ff <= 1'b1;
                        end else begin
                            ocnt_ff <= ocnt_ff + 3'h1;
                        end
                    end
                end
            end

            // three output dividers, each gated by its enable bit
            pcs_out_div u_div0 (
                .clk(clk),
                .ce(ce),
                .srst_n(srst_n),
                .en(ctl[`PCS_CTRL_OE_LSB]),
                .tick(pll_ff),
                .div_m1(cd[7:0]),
                .clk_out_ff(out0_w[g])
            );
            pcs_out_div u_div1 (
                .clk(clk),
                .ce(ce),
                .srst_n(srst_n),
                .en(ctl[`PCS_CTRL_OE_LSB+1]),
                .tick(pll_ff),
                .div_m1(cd[15:8]),
                .clk_out_ff(synth_out_one[g])
            );
            pcs_out_div u_div2 (
                .clk(clk),
                .ce(ce),
                .srst_n(srst_n),
                .en(ctl[`PCS_CTRL_OE_LSB+2]),
                .tick(pll_ff),
                .div_m1(cd[23:16]),
                .clk_out_ff(synth_out_two[g])
            );
            assign synth_out_zero[g] = out0_w[g];

            // feedback edge count per detector period; core mode listens to the
            // fabric return path, local mode to output zero directly
            wire fb_src = (fb == `PCS_FB_CORE) ? fabric_feedback_clock[g] : out0_w[g];
            wire fb_rise = fb_src & ~fb_q_ff;
            always @(posedge clk) begin
                if (!srst_n) begin
                    fb_q_ff <= 1'b0;
                    fbcnt_ff <= 8'h00;
                end else if (ce) begin
                    fb_q_ff <= fb_src;
                    if (pfd) begin
                        fbcnt_ff <= fb_rise ? 8'h01 : 8'h00;
                    end else if (fb_rise && fbcnt_ff != 8'hff) begin
                        fbcnt_ff <= fbcnt_ff + 8'h01;
                    end
                end
            end

            wire fb_ok = (fb == `PCS_FB_INT) || (fbcnt_ff == mv);

            pcs_lock_det u_lock (
                .clk(clk),
                .ce(ce),
                .srst_n(srst_n),
                .tick(pfd & pvalid_ff),
                .new_period(pcnt_ff + 16'h0001),
                .old_period(period_ff),
                .fb_ok(fb_ok),
                .locked_ff(locked[g])
            );

            assign stall_w[g] = (pcnt_ff == 16'hffff);
            assign period_w[g*16 +: 16] = period_ff;
        end
    endgenerate
endmodule // pcs_top

// ===== test/pcs_fabric_model.sv
// fabric side model: reference clock sources and the core feedback return path
`timescale 1ns/1ps
module pcs_fabric_model #(
    parameter int LVDS_HALF = 5
) (
    input wire logic clk,
    input wire logic ref_stop,
    input wire logic [4:0] synth_out_zero,
    output logic [19:0] ref_clock_inputs,
    output logic lvds_rx_ref_clock,
    output logic [4:0] fabric_feedback_clock
);
    int phase_ff = 0;
    // one free count paces every reference; stopping it freezes all lines at their level
    always @(posedge clk) begin
        if (!ref_stop) begin
            phase_ff <= phase_ff + 1;
        end
    end
    // reference k of each loop toggles every k+2 cycles, so each select gives its own period
    // no reference comes from a loop output, so loops are never cascaded
    for (genvar i = 0; i < 20; i++) begin : g_ref
        assign ref_clock_inputs[i] = ((phase_ff / ((i % 4) + 2)) % 2) == 1;
    end
    assign lvds_rx_ref_clock = ((phase_ff / LVDS_HALF) % 2) == 1;
    // core feedback returns the first output through the fabric
    assign fabric_feedback_clock = synth_out_zero;
endmodule // pcs_fabric_model

// ===== test/pcs_top_props.sv
// port checker for the clock synthesis control, bound to its top
`timescale 1ns/1ps
module pcs_top_props (
    input wire clk,
    input wire rst_n,
    input wire ce,
    input wire psel,
    input wire penable,
    input wire [7:0] paddr,
    input wire [31:0] prdata,
    input wire pready,
    input wire pslverr,
    input wire [4:0] locked
);
    default clocking cb @(posedge clk); endclocking
    default disable iff (!rst_n);
    // ce low freezes the bus logic, so only enabled setup cycles count
    wire setup = psel && !penable && ce;
    a_ready_after_setup: assert property (setup |=> pready)
        else $error("no ready after a setup cycle");
    a_ready_one_cycle: assert property (pready && ce |=> !pready)
        else $error("ready held too long");
    a_ready_has_cause: assert property ($rose(pready) |-> $past(setup))
        else $error("ready without a setup cycle");
    a_unmapped_refused: assert property (
        setup && paddr[7] |=> pslverr && prdata == 32'h00000000)
        else $error("unmapped access not refused");
    a_misaligned_refused: assert property (setup && paddr[1:0] != 2'h0 |=> pslverr)
        else $error("misaligned access not refused");
    a_mapped_accepted: assert property (
        setup && paddr[7:4] < 4'h5 && paddr[1:0] == 2'h0 |=> !pslverr)
        else $error("mapped access refused");
    a_read_data_hold: assert property (!setup |=> $stable(prdata) && $stable(pslverr))
        else $error("read data moved between accesses");
    a_reset_quiet: assert property (
        disable iff (1'b0) !rst_n |=> locked == 5'h00 && !pready)
        else $error("outputs not cleared by reset");
    a_lock_not_early: assert property ($rose(rst_n) |-> locked == 5'h00 [*8])
        else $error("lock shown too soon after reset");
endmodule // pcs_top_props

bind pcs_top pcs_top_props pcs_top_props_inst (.clk, .rst_n, .ce, .psel, .penable, .paddr,
    .prdata, .pready, .pslverr, .locked);

// ===== test/pll_clock_synth_control_tb_top.sv
// self-checking bench for the clock synthesis control
`timescale 1ns/1ps
`include "pcs_map.vh"
module pll_clock_synth_control_tb_top;
    logic clk = 1'b0, rst_n = 1'b0, ce = 1'b1, ref_stop = 1'b0;
    logic psel = 1'b0, penable = 1'b0, pwrite = 1'b0;
    logic [7:0] paddr = 8'h00;
    logic [31:0] pwdata = 32'h00000000, prdata, rd;
    logic pready, pslverr, er, lvds_rx_ref_clock;
    logic [19:0] ref_clock_inputs;
    logic [4:0] fabric_feedback_clock, synth_out_zero, synth_out_one, synth_out_two, locked, held;
    logic [19:0] snap;
    int num_errors = 0, samples_checked = 0, cycles = 0, g;
    int c [3];
    int rst_vals [3] = '{`PCS_CTRL_RST, `PCS_MN_RST, `PCS_CDIV_RST};
    // loop, source mode, select, pre-divider, expected detector period in cycles
    int rows [7][5] = '{'{0, 2, 0, 1, 4}, '{1, 2, 1, 2, 12}, '{3, 2, 2, 3, 24},
        '{4, 2, 3, 1, 10}, '{2, 0, 3, 1, 4}, '{2, 1, 0, 1, 6}, '{0, 3, 0, 1, 10}};

    always #50 clk = ~clk;

    pcs_top pcs_top_inst (.clk, .rst_n, .ce, .psel, .penable, .pwrite, .paddr, .pwdata, .prdata,
        .pready, .pslverr, .ref_clock_inputs, .lvds_rx_ref_clock, .fabric_feedback_clock,
        .synth_out_zero, .synth_out_one, .synth_out_two, .locked);
    pcs_fabric_model pcs_fabric_model_inst (.clk, .ref_stop, .synth_out_zero,
        .ref_clock_inputs, .lvds_rx_ref_clock, .fabric_feedback_clock);

    task automatic complete_run();
        if (num_errors == 0 && samples_checked > 0) begin
            $display("No errors found");
        end else begin
            $display("Errors were found");
        end
        $finish;
    endtask

    // range compare; lo equal to hi makes it exact, unknowns never pass
    task automatic chk(input logic [31:0] got, input int lo, input int hi);
        samples_checked++;
        if ($isunknown(got) || got < lo || got > hi) begin
            num_errors++;
            $display("wrong value at %0t: got %h, want %0d..%0d", $time, got, lo, hi);
        end
    endtask

    // one bus transfer: setup, then access held until ready is sampled high
    task automatic apb(input logic wr, input logic [7:0] a, input logic [31:0] d);
        int n = 0;
        @(posedge clk);
        psel <= 1'b1;
        penable <= 1'b0;
        pwrite <= wr;
        paddr <= a;
        pwdata <= d;
        @(posedge clk);
        penable <= 1'b1;
        do @(posedge clk); while (pready !== 1'b1);
        rd = prdata;
        er = pslverr;
        psel <= 1'b0;
        penable <= 1'b0;
    endtask

    function automatic logic [31:0] ctl(int sel, int src, int fb, int oc, int oe);
        return 32'(1 + (sel << 1) + (src << 3) + (fb << 5) + (oc << 8) + (oe << 10));
    endfunction

    // dividers first, then the select is changed only while the loop sits in reset
    task automatic cfg(input int lp, input logic [31:0] ctrl, mn, cdiv);
        logic [7:0] b;
        b = 8'(lp * 16);
        apb(1'b1, b + 8'h04, mn);
        apb(1'b1, b + 8'h08, cdiv);
        apb(1'b1, b, ctrl & ~32'h00000001);
        apb(1'b1, b, ctrl);
    endtask

    // bounded wait for a lock level; callers compare afterwards
    task automatic wait_lock(input int lp, input logic want);
        int n = 0;
        while (locked[lp] !== want && n < 2000) begin
            @(posedge clk);
            n++;
        end
    endtask

    // rising edges of the three outputs of one loop over 200 cycles
    task automatic count_edges(input int lp);
        logic [2:0] p, now;
        c = '{0, 0, 0};
        p = 3'h7;
        repeat (200) begin
            @(posedge clk);
            now = {synth_out_two[lp], synth_out_one[lp], synth_out_zero[lp]};
            for (int i = 0; i < 3; i++) if (now[i] === 1'b1 && p[i] === 1'b0) c[i]++;
            p = now;
        end
    endtask

    // hang guard, well above the roughly 2000 cycles the sequence needs
    always @(posedge clk) begin
        cycles <= cycles + 1;
        if (cycles == 20000) begin
            num_errors++;
            complete_run();
        end
    end

    initial begin
        repeat (6) @(posedge clk);
        rst_n <= 1'b1;
        chk(locked, 0, 0);
        for (int i = 0; i < 6; i++) begin
            apb(1'b0, 8'(i / 3 * 64 + i % 3 * 4), 32'h00000000);
            chk(rd, rst_vals[i % 3], rst_vals[i % 3]);
        end
        apb(1'b1, 8'h48, 32'h00070301);
        apb(1'b0, 8'h48, 32'h00000000);
        chk(rd, 32'h00070301, 32'h00070301);
        apb(1'b1, 8'h4c, 32'hffffffff);
        chk(er, 0, 0);
        apb(1'b1, 8'h42, 32'h00000fff);
        chk(er, 1, 1);
        apb(1'b0, 8'h80, 32'h00000000);
        chk({rd[30:0], er}, 1, 1);
        apb(1'b0, 8'h44, 32'h00000000);
        chk(rd, `PCS_MN_RST, `PCS_MN_RST);
        // each row: program, wait for lock, read the detector period back
        foreach (rows[r]) begin
            g = rows[r][0];
            cfg(g, ctl(rows[r][2], rows[r][1], 0, 0, 0), 32'(rows[r][3] * 256 + 1), 0);
            wait_lock(g, 1'b1);
            chk(locked[g], 1, 1);
            apb(1'b0, 8'(g * 16 + 12), 32'h00000000);
            chk(rd[31:16], rows[r][4], rows[r][4]);
        end
        // stalled references must leave every lock flag where it was
        held = locked;
        ref_stop <= 1'b1;
        repeat (300) @(posedge clk);
        chk(locked, held, held);
        ref_stop <= 1'b0;
        wait_lock(4, 1'b0);
        chk(locked[4], 0, 0);
        wait_lock(4, 1'b1);
        chk(locked[4], 1, 1);
        apb(1'b1, 8'h40, ctl(3, 2, 0, 0, 0) & ~32'h00000001);
        repeat (100) @(posedge clk);
        chk(locked[4], 0, 0);
        // internal feedback: M=8, O=2, C=2/4/8 on a 10-cycle detector period
        cfg(1, ctl(3, 2, 0, 1, 7), 32'h00000108, 32'h00070301);
        wait_lock(1, 1'b1);
        count_edges(1);
        chk(c[0], 38, 42);
        chk(c[1], 18, 22);
        chk(c[2], 8, 12);
        // local then core feedback: M=3, N=2, O=2, C=2/2/4 on a 20-cycle period
        for (int fb = 1; fb < 3; fb++) begin
            cfg(4 - fb, ctl(3, 2, fb, 1, 7), 32'h00000203, 32'h00030101);
            wait_lock(4 - fb, 1'b1);
            chk(locked[4 - fb], 1, 1);
            count_edges(4 - fb);
            chk(c[0], 28, 32);
            chk(c[1], 28, 32);
            chk(c[2], 13, 17);
        end
        // clock enable low freezes every loop and its outputs
        ce <= 1'b0;
        @(posedge clk);
        snap = {synth_out_two, synth_out_one, synth_out_zero, locked};
        repeat (50) @(posedge clk);
        chk({synth_out_two, synth_out_one, synth_out_zero, locked}, snap, snap);
        // mid-run reset returns registers and lock flags to their reset state
        ce <= 1'b1;
        rst_n <= 1'b0;
        repeat (2) @(posedge clk);
        rst_n <= 1'b1;
        chk(locked, 0, 0);
        apb(1'b0, 8'h30, 32'h00000000);
        chk(rd, `PCS_CTRL_RST, `PCS_CTRL_RST);
        complete_run();
    end
endmodule // pll_clock_synth_control_tb_top
